// ==== pkg/otc_pkg.sv ====
package otc_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_OUT = 32;
	localparam int OUT_IDX_W = 5;
	localparam int PAT_W = 16;
	localparam int TIME_W = 32;
	localparam int TICK_W = 64;
	localparam int SLOT_IDX_W = 6;
	localparam int MAX_SLOTS = 64;
	localparam int DEF_SLOTS = 64;
	localparam int PROC_IDX_W = 5;
	localparam int MAX_PROCS = 32;
	localparam int DEF_PROCS = 8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_PERIOD_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_SLOT_SEL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FIRST_OUT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PATTERN = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PERIOD_MS = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_TIMER_CMD = 8'h10;
	localparam logic [ADDR_W-1:0] REG_OUT_BASE = 8'h14;
	localparam logic [ADDR_W-1:0] REG_OUT_STATE = 8'h18;
	localparam logic [ADDR_W-1:0] REG_ACTIVE_LO = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_ACTIVE_HI = 8'h20;
	localparam logic [ADDR_W-1:0] REG_PROC_SEL = 8'h24;
	localparam logic [ADDR_W-1:0] REG_TICKS_LO = 8'h28;
	localparam logic [ADDR_W-1:0] REG_TICKS_HI = 8'h2C;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CMD_START_BIT = 0;
	localparam int CMD_INVERT_BIT = 1;
	localparam logic [PAT_W-1:0] SINGLE_PATTERN = 16'h0001;
	localparam logic [NUM_OUT-1:0] OUT_BASE_RST = 32'h0000_0000;
	localparam logic [PAT_W-1:0] PATTERN_RST = 16'h0001;
	localparam logic [TIME_W-1:0] PERIOD_RST = 32'h0000_0000;
	localparam logic [TICK_W-1:0] TICKS_RST = 64'h0000_0000_0000_0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage : otc_pkg

// ==== logic/otc_tick_bank.sv ====
`timescale 1ns/1ns

module otc_tick_bank
	import otc_pkg::*;
#(
	parameter int NUM_PROC = DEF_PROCS
)
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic servo_tick_in,
	input wire logic wr_in,
	input wire logic [PROC_IDX_W-1:0] wr_proc_in,
	input wire logic [TICK_W-1:0] wr_val_in,
	input wire logic [PROC_IDX_W-1:0] rd_proc_in,
	output logic [TICK_W-1:0] rd_val_out
);

	typedef struct packed {
		logic [NUM_PROC-1:0][TICK_W-1:0] cnt;
	} otc_bank_s;

	otc_bank_s q, d;

	// ----------------------------------------------------------------
	// One counter per process, all counting down together
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		for (int p = 0; p < NUM_PROC; p++)
		begin
			if (servo_tick_in)
				d.cnt[p] = q.cnt[p] - 64'h0000_0000_0000_0001;
			// A write in the tick cycle wins: the written value is the
			// new start point and the countdown resumes on the next tick.
			if (wr_in && (32'(wr_proc_in) == p))
				d.cnt[p] = wr_val_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			q <= '0;
		else
			q <= d;
	end

	always_comb
	begin
		rd_val_out = TICKS_RST;
		if (32'(rd_proc_in) < NUM_PROC)
			rd_val_out = q.cnt[rd_proc_in];
	end

endmodule : otc_tick_bank

// ==== logic/otc_top.sv ====
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ns

// Function
// - There are sixty-four independent timer slots, each able to drive any output.
// - A pattern of one means a single output, anything else is a 16-bit mask.
// - The period of each slot is counted in milliseconds.
// - Without the invert option the outputs go on at start and off at expiry.
// - With the invert option the outputs go off at start and on at expiry.
// - Outputs whose mask bit is zero are left under ordinary control.
// - A 64-bit tick counter decreases by one on every servo cycle.
// - The tick counter is readable and writable; a write restarts the count.
// - Each process has its own tick counter, handled independently.

module otc_top
	import otc_pkg::*;
#(
	parameter int NUM_SLOTS = DEF_SLOTS,
	parameter int NUM_PROC = DEF_PROCS,
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic SERVO_TICK_IN,
	output logic [DATA_W-1:0] RDATA_OUT,
	output logic [NUM_OUT-1:0] OUTPUTS_OUT
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (NUM_SLOTS < 1 || NUM_SLOTS > MAX_SLOTS)
	begin : g_bad_slots
		$error("NUM_SLOTS must lie between 1 and 64");
	end
	if (NUM_PROC < 1 || NUM_PROC > MAX_PROCS)
	begin : g_bad_procs
		$error("NUM_PROC must lie between 1 and 32");
	end
	if (MS_CYCLES < 1)
	begin : g_bad_ms
		$error("MS_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_SLOTS-1:0] act;
		logic [NUM_SLOTS-1:0] inv;
		logic [NUM_SLOTS-1:0][OUT_IDX_W-1:0] first;
		logic [NUM_SLOTS-1:0][PAT_W-1:0] pat;
		logic [NUM_SLOTS-1:0][TIME_W:0] rem;
		logic [SLOT_IDX_W-1:0] slot_sel;
		logic [OUT_IDX_W-1:0] first_stage;
		logic [PAT_W-1:0] pat_stage;
		logic [TIME_W-1:0] period_stage;
		logic [NUM_OUT-1:0] base;
		logic [NUM_OUT-1:0] outs;
		logic [31:0] presc;
		logic [PROC_IDX_W-1:0] proc_sel;
		logic [DATA_W-1:0] tick_lo_stage;
		logic [DATA_W-1:0] tick_hi_snap;
		logic [DATA_W-1:0] rdata;
	} otc_state_s;

	otc_state_s q, d;

	logic tick_wr;
	logic [TICK_W-1:0] tick_wr_val;
	logic [TICK_W-1:0] tick_rd_val;
	logic [MAX_SLOTS-1:0] act_wide;

	// ----------------------------------------------------------------
	// Output mask of a slot
	// ----------------------------------------------------------------
	// Mask bits that would land above the last output are dropped, so a
	// wide pattern near the top of the bank simply covers fewer outputs.
	function automatic logic [NUM_OUT-1:0] slot_mask(
		input logic [OUT_IDX_W-1:0] first,
		input logic [PAT_W-1:0] pat
	);
		logic [NUM_OUT-1:0] m;
		m = '0;
		if (pat == SINGLE_PATTERN)
			m[first] = 1'b1;
		else
			m = NUM_OUT'({16'h0000, pat} << first);
		return m;
	endfunction : slot_mask

	// ----------------------------------------------------------------
	// Tick counters
	// ----------------------------------------------------------------
	// The 64-bit value is written low half first into a stage; the high
	// write commits both halves at once so the countdown never sees a
	// half-written value.
	assign tick_wr = WR_IN && (ADDR_IN == REG_TICKS_HI);
	assign tick_wr_val = {WDATA_IN, q.tick_lo_stage};
	assign act_wide = MAX_SLOTS'(q.act);

	otc_tick_bank #(
		.NUM_PROC(NUM_PROC)
	) u_ticks (
		.clk_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.servo_tick_in(SERVO_TICK_IN),
		.wr_in(tick_wr),
		.wr_proc_in(q.proc_sel),
		.wr_val_in(tick_wr_val),
		.rd_proc_in(q.proc_sel),
		.rd_val_out(tick_rd_val)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic ms_tick;
		logic [NUM_OUT-1:0] m;
		logic [NUM_OUT-1:0] o;
		ms_tick = 1'b0;
		m = '0;
		o = '0;
		d = q;

		// Millisecond time base; free running, so the first millisecond
		// of a period is partial and one extra is added on load.
		if (q.presc >= 32'(MS_CYCLES - 1))
		begin
			d.presc = '0;
			ms_tick = 1'b1;
		end
		else
			d.presc = q.presc + 32'h0000_0001;

		// Expiry returns each masked output to its end level.
		for (int s = 0; s < NUM_SLOTS; s++)
		begin
			if (ms_tick && q.act[s])
			begin
				d.rem[s] = q.rem[s] - (TIME_W+1)'(1);
				if (q.rem[s] <= (TIME_W+1)'(1))
				begin
					d.act[s] = 1'b0;
					m = slot_mask(q.first[s], q.pat[s]);
					if (q.inv[s])
						d.base = d.base | m;
					else
						d.base = d.base & ~m;
				end
			end
		end

		// Register writes.
		if (WR_IN)
		begin
			unique case (ADDR_IN)
			REG_SLOT_SEL: d.slot_sel = WDATA_IN[SLOT_IDX_W-1:0];
			REG_FIRST_OUT: d.first_stage = WDATA_IN[OUT_IDX_W-1:0];
			REG_PATTERN: d.pat_stage = WDATA_IN[PAT_W-1:0];
			REG_PERIOD_MS: d.period_stage = WDATA_IN[TIME_W-1:0];
			REG_OUT_BASE: d.base = WDATA_IN[NUM_OUT-1:0];
			REG_PROC_SEL: d.proc_sel = WDATA_IN[PROC_IDX_W-1:0];
			REG_TICKS_LO: d.tick_lo_stage = WDATA_IN;
			REG_TIMER_CMD:
			begin
				// A start on a running slot overrides its expiry in the
				// same cycle and times the new period from here.
				if (WDATA_IN[CMD_START_BIT] &&
					32'(q.slot_sel) < NUM_SLOTS)
				begin
					d.act[q.slot_sel] = 1'b1;
					d.inv[q.slot_sel] = WDATA_IN[CMD_INVERT_BIT];
					d.first[q.slot_sel] = q.first_stage;
					d.pat[q.slot_sel] = q.pat_stage;
					d.rem[q.slot_sel] =
						(TIME_W+1)'({1'b0, q.period_stage}) +
						(TIME_W+1)'(1);
				end
			end
			default:
			begin
			end
			endcase
		end

		// Output levels: ordinary control, overridden by running slots.
		// Where slots overlap, the highest slot index wins.
		o = d.base;
		for (int s = 0; s < NUM_SLOTS; s++)
		begin
			if (d.act[s])
			begin
				m = slot_mask(d.first[s], d.pat[s]);
				if (d.inv[s])
					o = o & ~m;
				else
					o = o | m;
			end
		end
		d.outs = o;

		// Register reads, answered in the next cycle.
		d.rdata = READ_ZERO;
		if (RD_IN)
		begin
			unique case (ADDR_IN)
			REG_SLOT_SEL: d.rdata = DATA_W'(q.slot_sel);
			REG_FIRST_OUT: d.rdata = DATA_W'(q.first_stage);
			REG_PATTERN: d.rdata = DATA_W'(q.pat_stage);
			REG_PERIOD_MS: d.rdata = q.period_stage;
			REG_OUT_BASE: d.rdata = q.base;
			REG_OUT_STATE: d.rdata = q.outs;
			REG_ACTIVE_LO: d.rdata = act_wide[31:0];
			REG_ACTIVE_HI: d.rdata = act_wide[63:32];
			REG_PROC_SEL: d.rdata = DATA_W'(q.proc_sel);
			REG_TICKS_LO:
			begin
				// Reading the low half freezes the high half so that a
				// borrow between the two reads cannot tear the value.
				d.rdata = tick_rd_val[31:0];
				d.tick_hi_snap = tick_rd_val[63:32];
			end
			REG_TICKS_HI: d.rdata = q.tick_hi_snap;
			default: d.rdata = READ_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			q <= '0;
			q.base <= OUT_BASE_RST;
			q.outs <= OUT_BASE_RST;
			q.pat_stage <= PATTERN_RST;
			q.period_stage <= PERIOD_RST;
		end
		else
			q <= d;
	end

	assign RDATA_OUT = q.rdata;
	assign OUTPUTS_OUT = q.outs;

endmodule : otc_top

// ==== sim/otc_top_sva.sv ====
`timescale 1ns/1ns
module otc_top_sva
	import otc_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic SERVO_TICK_IN,
	input wire logic [DATA_W-1:0] RDATA_OUT,
	input wire logic [NUM_OUT-1:0] OUTPUTS_OUT
);
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	idle_rd_zero_a: assert property (
		!RD_IN |=> RDATA_OUT == READ_ZERO) else $error("stray read data");
	cmd_rd_zero_a: assert property (
		RD_IN && ADDR_IN == REG_TIMER_CMD |=> RDATA_OUT == READ_ZERO)
		else $error("command register read not zero");
	unmapped_rd_a: assert property (
		RD_IN && ADDR_IN >= 8'h30 |=> RDATA_OUT == READ_ZERO)
		else $error("unmapped read not zero");
	state_rd_a: assert property (
		RD_IN && ADDR_IN == REG_OUT_STATE |=> RDATA_OUT == $past(OUTPUTS_OUT))
		else $error("output state read wrong");
	slot_back_a: assert property (
		WR_IN && ADDR_IN == REG_SLOT_SEL
		##1 !(WR_IN && ADDR_IN == REG_SLOT_SEL)
		##1 RD_IN && ADDR_IN == REG_SLOT_SEL
		|=> RDATA_OUT == ($past(WDATA_IN, 3) & 32'h3F)) else $error("slot");
	first_back_a: assert property (
		WR_IN && ADDR_IN == REG_FIRST_OUT
		##1 !(WR_IN && ADDR_IN == REG_FIRST_OUT)
		##1 RD_IN && ADDR_IN == REG_FIRST_OUT
		|=> RDATA_OUT == ($past(WDATA_IN, 3) & 32'h1F)) else $error("first");
	pat_back_a: assert property (
		WR_IN && ADDR_IN == REG_PATTERN
		##1 !(WR_IN && ADDR_IN == REG_PATTERN)
		##1 RD_IN && ADDR_IN == REG_PATTERN
		|=> RDATA_OUT == ($past(WDATA_IN, 3) & 32'hFFFF)) else $error("pattern");
	per_back_a: assert property (
		WR_IN && ADDR_IN == REG_PERIOD_MS
		##1 !(WR_IN && ADDR_IN == REG_PERIOD_MS)
		##1 RD_IN && ADDR_IN == REG_PERIOD_MS
		|=> RDATA_OUT == $past(WDATA_IN, 3)) else $error("period");
	proc_back_a: assert property (
		WR_IN && ADDR_IN == REG_PROC_SEL
		##1 !(WR_IN && ADDR_IN == REG_PROC_SEL)
		##1 RD_IN && ADDR_IN == REG_PROC_SEL
		|=> RDATA_OUT == ($past(WDATA_IN, 3) & 32'h1F)) else $error("process");
endmodule : otc_top_sva
bind otc_top otc_top_sva i_otc_top_sva (.CLOCK_IN, .RSTN_IN, .ADDR_IN,
	.WDATA_IN, .WR_IN, .RD_IN, .SERVO_TICK_IN, .RDATA_OUT, .OUTPUTS_OUT);

// ==== sim/otc_top_tb.sv ====
`timescale 1ns/1ns
module otc_top_tb;
	import otc_pkg::*;
	// A short millisecond keeps every timed hold to a few dozen cycles.
	localparam int MS = 10;
	logic CLOCK_IN = 0;
	logic RSTN_IN = 0;
	logic [ADDR_W-1:0] ADDR_IN = '0;
	logic [DATA_W-1:0] WDATA_IN = '0;
	logic WR_IN = 0;
	logic RD_IN = 0;
	logic SERVO_TICK_IN = 0;
	logic [DATA_W-1:0] RDATA_OUT;
	logic [NUM_OUT-1:0] OUTPUTS_OUT;
	logic rd_d = 0;
	logic [DATA_W-1:0] exp_q[$];
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	logic [31:0] r, b, e;
	logic [63:0] t, t1, t2;
	otc_top #(.MS_CYCLES(MS)) i_otc_top (.CLOCK_IN, .RSTN_IN, .ADDR_IN,
		.WDATA_IN, .WR_IN, .RD_IN, .SERVO_TICK_IN, .RDATA_OUT, .OUTPUTS_OUT);
	// ----------------------------------------------------------------
	// Bus tasks and checking
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			fail_count++;
			$display("FAIL at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask : chk
	// Each strobe is followed by one idle cycle, so no task re-raises it
	// in the same time step that lowered it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ADDR_IN <= a;
		WDATA_IN <= d;
		WR_IN <= 1'b1;
		@(posedge CLOCK_IN);
		WR_IN <= 1'b0;
		@(posedge CLOCK_IN);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		@(posedge CLOCK_IN);
		RD_IN <= 1'b0;
		@(posedge CLOCK_IN);
	endtask : rd
	task automatic start(input int s, f, p, per, c);
		wr(REG_SLOT_SEL, 32'(s));
		wr(REG_FIRST_OUT, 32'(f));
		wr(REG_PATTERN, 32'(p));
		wr(REG_PERIOD_MS, 32'(per));
		wr(REG_TIMER_CMD, 32'(c));
	endtask : start
	// Outputs are looked at on the falling edge, where they have settled,
	// and the task hands back on a rising edge so the next drive is on it.
	task automatic look(input logic [31:0] want);
		@(negedge CLOCK_IN);
		chk(OUTPUTS_OUT, want);
		@(posedge CLOCK_IN);
	endtask : look
	task automatic wait_out(input logic [31:0] want);
		n = 0;
		@(negedge CLOCK_IN);
		while (OUTPUTS_OUT !== want && n < 200)
		begin
			@(negedge CLOCK_IN);
			n++;
		end
		chk(OUTPUTS_OUT, want);
		@(posedge CLOCK_IN);
	endtask : wait_out
	always @(posedge CLOCK_IN) rd_d <= RD_IN;
	always @(negedge CLOCK_IN) if (rd_d) chk(RDATA_OUT, exp_q.pop_front());
	always @(posedge CLOCK_IN)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		forever #50 CLOCK_IN = ~CLOCK_IN;
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		r = $urandom(95);
		repeat (10) @(posedge CLOCK_IN);
		RSTN_IN <= 1'b1;
		rd(REG_OUT_BASE, 32'h0);
		rd(REG_PATTERN, 32'h1);
		rd(REG_TICKS_LO, 32'h0);
		rd(REG_ACTIVE_LO, 32'h0);
		rd(8'h30, 32'h0);
		r = $urandom;
		wr(REG_SLOT_SEL, r);
		rd(REG_SLOT_SEL, r & 32'h3F);
		wr(REG_FIRST_OUT, r);
		rd(REG_FIRST_OUT, r & 32'h1F);
		wr(REG_PATTERN, r);
		rd(REG_PATTERN, r & 32'hFFFF);
		wr(REG_PERIOD_MS, r);
		rd(REG_PERIOD_MS, r);
		wr(REG_PROC_SEL, r);
		rd(REG_PROC_SEL, r & 32'h1F);
		$display("test 1 done");
		start(0, 8, 1, 3, 1);
		look(32'h100);
		rd(REG_ACTIVE_LO, 32'h1);
		wait_out(32'h0);
		chk(32'(n >= 3 * MS - 3 && n <= 4 * MS), 32'h1);
		$display("test 2 done");
		b = $urandom;
		e = 32'h0000_3400;
		wr(REG_OUT_BASE, b);
		start(63, 10, 13, 2, 3);
		look(b & ~e);
		rd(REG_ACTIVE_HI, 32'h8000_0000);
		rd(REG_OUT_STATE, b & ~e);
		wait_out(b | e);
		chk(32'(n >= 2 * MS - 7 && n <= 3 * MS), 32'h1);
		rd(REG_OUT_BASE, b | e);
		rd(REG_ACTIVE_HI, 32'h0);
		$display("test 3 done");
		wr(REG_OUT_BASE, 32'h0);
		for (int k = 0; k < 3; k++)
		begin
			r = $urandom;
			start(r[29:24], r[20:16], r[15:0], 1, 1);
			look(32'(r[15:0]) << r[20:16]);
			wait_out(32'h0);
		end
		$display("test 4 done");
		// The restart comes late enough that the first period would
		// already have ended early had it not been reloaded.
		start(5, 0, 1, 2, 1);
		repeat (15) @(posedge CLOCK_IN);
		wr(REG_TIMER_CMD, 32'h1);
		look(32'h1);
		wait_out(32'h0);
		chk(32'(n >= 2 * MS - 3 && n <= 3 * MS), 32'h1);
		$display("test 5 done");
		t1 = {$urandom, $urandom};
		t2 = {$urandom, $urandom};
		wr(REG_PROC_SEL, 32'h1);
		wr(REG_TICKS_LO, t1[31:0]);
		wr(REG_TICKS_HI, t1[63:32]);
		wr(REG_PROC_SEL, 32'h2);
		wr(REG_TICKS_LO, t2[31:0]);
		wr(REG_TICKS_HI, t2[63:32]);
		repeat (3)
		begin
			SERVO_TICK_IN <= 1'b1;
			@(posedge CLOCK_IN);
			SERVO_TICK_IN <= 1'b0;
			@(posedge CLOCK_IN);
		end
		for (int k = 0; k < 3; k++)
		begin
			t = (k == 0 ? 64'h0 : k == 1 ? t1 : t2) - 64'h3;
			wr(REG_PROC_SEL, 32'(k));
			rd(REG_TICKS_LO, t[31:0]);
			rd(REG_TICKS_HI, t[63:32]);
		end
		$display("test 6 done");
		give_verdict();
	end
endmodule : otc_top_tb
